// *** common/gqpc_pkg.sv ***
// Package with constants and types of the gated quadrature and pulse counter
package gqpc_pkg;

    localparam int COUNT_WIDTH = 28;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 9;
    localparam int STAT_W = 2;
    localparam int SYNC_N = 3;

    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PRESET = 8'h04;
    localparam logic [7:0] OFS_VALUE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_CLEAR = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] OFS_RUN = 8'h18;

    // Status bit positions
    localparam int ST_OVF_BIT = 0;
    localparam int ST_UNF_BIT = 1;

    // Counting modes
    localparam logic [1:0] MODE_PULSE_DIR = 2'h0;
    localparam logic [1:0] MODE_QUADRATURE_SINGLE_RATE = 2'h1;
    localparam logic [1:0] MODE_QUADRATURE_DOUBLE_RATE = 2'h2;
    localparam logic [1:0] MODE_QUADRATURE_QUAD_RATE = 2'h3;

    // Gate modes
    localparam logic [1:0] GATE_OFF = 2'h0;
    localparam logic [1:0] GATE_LEVEL = 2'h1;
    localparam logic [1:0] GATE_EDGE = 2'h2;

    typedef struct packed {
        logic retrig;
        logic gate_low;
        logic [1:0] gate_mode;
        logic repeat_en;
        logic reload_en;
        logic [1:0] count_mode;
        logic enable;
    } ctrl_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_HALT = 3'b100
    } run_state_e;

    // Values after reset
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    localparam logic [DATA_W-1:0] PRESET_RST = 32'h0000_0000;
    localparam logic [STAT_W-1:0] STAT_RST = 2'h0;

endpackage

// *** design/gated_quadrature_pulse_counter.sv ***
// One gated quadrature and pulse-direction counter channel with register port
`timescale 1ns/1ps

module gated_quadrature_pulse_counter
    import gqpc_pkg::*;
#(
    parameter int CNT_W = COUNT_WIDTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_count_input_a,
    input wire logic i_count_input_b,
    input wire logic i_gate_input,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter check

    generate
        if (CNT_W < 2 || CNT_W > DATA_W) begin : g_bad_width
            $error("CNT_W out of range");
        end
    endgenerate

    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] CNT_MIN = '0;

    // Step decode: returns {valid, up}
    function automatic logic [1:0] step_decode(
        input logic [1:0] mode,
        input logic a_old,
        input logic b_old,
        input logic a_new,
        input logic b_new
    );
        logic a_chg;
        logic b_chg;
        a_chg = a_old ^ a_new;
        b_chg = b_old ^ b_new;
        step_decode = 2'h0;
        case (mode)
            MODE_PULSE_DIR: begin
                step_decode = {a_chg & a_new, b_new};
            end
            MODE_QUADRATURE_SINGLE_RATE: begin
                step_decode = {a_chg & a_new, ~b_new};
            end
            MODE_QUADRATURE_DOUBLE_RATE: begin
                step_decode = {a_chg, a_new ^ b_new};
            end
            MODE_QUADRATURE_QUAD_RATE: begin
                if (a_chg) begin
                    step_decode = {1'b1, a_new ^ b_new};
                end else if (b_chg) begin
                    step_decode = {1'b1, ~(a_new ^ b_new)};
                end
            end
            default: begin
                step_decode = 2'h0;
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and agreement filter

    logic [SYNC_N-1:0] pin_in;
    logic [SYNC_N-1:0] s1_reg, s1_next;
    logic [SYNC_N-1:0] s2_reg, s2_next;
    logic [SYNC_N-1:0] s3_reg, s3_next;
    logic [SYNC_N-1:0] filt_reg, filt_next;

    assign pin_in = {i_gate_input, i_count_input_b, i_count_input_a};

    always_comb begin
        s1_next = pin_in;
        s2_next = s1_reg;
        s3_next = s2_reg;
        for (int i = 0; i < SYNC_N; i++) begin
            filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
        end else if (i_ce) begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            filt_reg <= filt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers written by software

    ctrl_s ctrl_reg, ctrl_next;
    logic [CNT_W-1:0] preset_reg, preset_next;
    logic [STAT_W-1:0] irq_en_reg, irq_en_next;
    logic [STAT_W-1:0] clr_pulse;

    always_comb begin
        ctrl_next = ctrl_reg;
        preset_next = preset_reg;
        irq_en_next = irq_en_reg;
        clr_pulse = '0;
        if (i_wr) begin
            case (i_addr)
                OFS_CTRL: ctrl_next = ctrl_s'(i_wdata[CTRL_W-1:0]);
                OFS_PRESET: preset_next = i_wdata[CNT_W-1:0];
                OFS_IRQ_EN: irq_en_next = i_wdata[STAT_W-1:0];
                OFS_CLEAR: clr_pulse = i_wdata[STAT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_reg <= ctrl_s'(CTRL_RST);
            preset_reg <= PRESET_RST[CNT_W-1:0];
            irq_en_reg <= STAT_RST;
        end else if (i_ce) begin
            ctrl_reg <= ctrl_next;
            preset_reg <= preset_next;
            irq_en_reg <= irq_en_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate

    logic gate_lvl;
    logic gate_edge;
    logic gate_open;
    logic gate_seen_reg, gate_seen_next;
    logic gate_done_reg, gate_done_next;
    logic started_reg, started_next;

    always_comb begin
        gate_lvl = filt_next[2] ^ ctrl_reg.gate_low;
        gate_edge = (filt_next[2] ^ filt_reg[2]) & gate_lvl;
        gate_seen_next = gate_seen_reg | gate_lvl;
        gate_done_next = gate_done_reg | (gate_seen_reg & ~gate_lvl);
        started_next = started_reg | gate_edge;
        if (!ctrl_reg.enable) begin
            gate_seen_next = 1'b0;
            gate_done_next = 1'b0;
            started_next = 1'b0;
        end
        case (ctrl_reg.gate_mode)
            GATE_OFF: gate_open = 1'b1;
            GATE_LEVEL: begin
                // One run only unless retriggerable
                gate_open = gate_lvl & (ctrl_reg.retrig | ~gate_done_reg);
            end
            GATE_EDGE: gate_open = started_reg;
            default: gate_open = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gate_seen_reg <= 1'b0;
            gate_done_reg <= 1'b0;
            started_reg <= 1'b0;
        end else if (i_ce) begin
            gate_seen_reg <= gate_seen_next;
            gate_done_reg <= gate_done_next;
            started_reg <= started_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    run_state_e state_reg, state_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic [1:0] step;
    logic ovf_evt;
    logic unf_evt;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        ovf_evt = 1'b0;
        unf_evt = 1'b0;
        step = step_decode(ctrl_reg.count_mode, filt_reg[0], filt_reg[1],
                           filt_next[0], filt_next[1]);
        case (state_reg)
            ST_IDLE: begin
                if (ctrl_reg.enable) begin
                    count_next = preset_reg;
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!ctrl_reg.enable) begin
                    state_next = ST_IDLE;
                end else if (step[1] && gate_open) begin
                    if (step[0] && count_reg == CNT_MAX) begin
                        ovf_evt = 1'b1;
                        count_next = ctrl_reg.reload_en ? preset_reg : CNT_MAX;
                        if (!ctrl_reg.repeat_en) begin
                            state_next = ST_HALT;
                        end
                    end else if (!step[0] && count_reg == CNT_MIN) begin
                        unf_evt = 1'b1;
                        count_next = ctrl_reg.reload_en ? preset_reg : CNT_MIN;
                        if (!ctrl_reg.repeat_en) begin
                            state_next = ST_HALT;
                        end
                    end else if (step[0]) begin
                        count_next = count_reg + 1'b1;
                    end else begin
                        count_next = count_reg - 1'b1;
                    end
                end
            end
            ST_HALT: begin
                if (!ctrl_reg.enable) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            count_reg <= '0;
        end else if (i_ce) begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status, interrupt and read data

    logic [STAT_W-1:0] status_reg, status_next;
    logic irq_next;
    logic [DATA_W-1:0] rdata_next;
    logic [STAT_W-1:0] evt;

    always_comb begin
        evt = '0;
        evt[ST_OVF_BIT] = ovf_evt;
        evt[ST_UNF_BIT] = unf_evt;
        // A new event beats a clear in the same cycle
        status_next = (status_reg & ~clr_pulse) | evt;
        irq_next = |(status_next & irq_en_next);
        rdata_next = '0;
        if (i_rd) begin
            case (i_addr)
                OFS_CTRL: rdata_next[CTRL_W-1:0] = ctrl_reg;
                OFS_PRESET: rdata_next[CNT_W-1:0] = preset_reg;
                OFS_VALUE: rdata_next[CNT_W-1:0] = count_reg;
                OFS_STATUS: rdata_next[STAT_W-1:0] = status_reg;
                OFS_IRQ_EN: rdata_next[STAT_W-1:0] = irq_en_reg;
                OFS_RUN: rdata_next[2:0] = {gate_open, state_reg == ST_HALT,
                                            state_reg == ST_RUN};
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            status_reg <= STAT_RST;
            o_irq <= 1'b0;
            o_rdata <= '0;
        end else if (i_ce) begin
            status_reg <= status_next;
            o_irq <= irq_next;
            o_rdata <= rdata_next;
        end
    end

endmodule

// *** dv/gated_quadrature_pulse_counter_assertions.sv ***
// Port checker of the counter channel
`timescale 1ns/1ps
module gqpc_checker
    import gqpc_pkg::*;
#(
    parameter int CNT_W = COUNT_WIDTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_count_input_a,
    input wire logic i_count_input_b,
    input wire logic i_gate_input,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic rv_q;
    logic held;
    logic [1:0] ien;
    logic [CTRL_W-1:0] ctl;
    logic [DATA_W-1:0] last_v;
    ////////////////////////////////////////////////////////////////////////
    // Shadow of control, interrupt enable and last value read
    always_ff @(posedge i_clk) begin
        rv_q <= i_rd && i_addr == OFS_VALUE;
        if (rv_q) last_v <= o_rdata;
        if (i_rst) begin
            ctl <= CTRL_RST;
            ien <= 2'h0;
            held <= 1'b0;
        end else begin
            if (i_wr && i_addr == OFS_IRQ_EN) ien <= i_wdata[1:0];
            if (i_wr && i_addr == OFS_CTRL) ctl <= i_wdata[CTRL_W-1:0];
            if (rv_q) held <= !ctl[0];
            if (i_wr && i_addr == OFS_CTRL) held <= 1'b0;
        end
    end
    sequence s_stat_rd;
        i_rd && i_addr == OFS_STATUS;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_reset_quiet: assert property ($past(i_rst) |-> o_rdata == '0 && !o_irq)
        else $error("Outputs not quiet after reset");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("Read data outside read answer");
    a_ctrl_back: assert property (
        $past(i_rd && i_addr == OFS_CTRL) |-> o_rdata == DATA_W'($past(ctl)))
        else $error("Control readback wrong");
    a_value_width: assert property ($past(i_rd && i_addr == OFS_VALUE) |-> (o_rdata >> CNT_W) == '0)
        else $error("Value upper bits set");
    a_status_width: assert property (s_stat_rd |=> o_rdata[DATA_W-1:STAT_W] == '0)
        else $error("Status upper bits set");
    a_unmapped_zero: assert property ($past(i_rd && i_addr > OFS_RUN) |-> o_rdata == '0)
        else $error("Unmapped read not zero");
    a_value_frozen: assert property (rv_q && held |-> o_rdata == last_v)
        else $error("Value moved while disabled");
    a_irq_enabled: assert property (o_irq |-> ien != 2'h0 || $past(ien) != 2'h0)
        else $error("Interrupt without enable");
    a_irq_cause: assert property (
        (o_irq && !$past(i_wr)) and s_stat_rd |=> (o_rdata[1:0] & $past(ien)) != 2'h0)
        else $error("Interrupt without enabled status");
endmodule

bind gated_quadrature_pulse_counter gqpc_checker #(.CNT_W(CNT_W)) i_gqpc_checker (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_count_input_a(i_count_input_a),
    .i_count_input_b(i_count_input_b), .i_gate_input(i_gate_input),
    .o_rdata(o_rdata), .o_irq(o_irq));

// *** dv/encoder_source_model.sv ***
// Encoder and pulse source driving the two count lines
`timescale 1ns/1ps
module encoder_source_model (
    input wire logic i_clk,
    output logic o_a,
    output logic o_b
);
    int hold = 6;
    logic [1:0] ph = 2'h0;
    initial begin
        o_a = 1'b0;
        o_b = 1'b0;
    end
    task automatic wait_hold();
        repeat (hold) @(posedge i_clk);
    endtask
    // Quarter step; A leads B when moving up
    task automatic quad(input logic up);
        @(posedge i_clk);
        ph = up ? ph + 2'h1 : ph - 2'h1;
        o_a <= ph[1] ^ ph[0];
        o_b <= ph[1];
        wait_hold();
    endtask
    // Direction on B, then one pulse on A
    task automatic pulse(input logic up);
        @(posedge i_clk);
        o_b <= up;
        wait_hold();
        o_a <= 1'b1;
        wait_hold();
        o_a <= 1'b0;
        wait_hold();
    endtask
endmodule

// *** dv/test_gated_quadrature_pulse_counter.sv ***
// Self-checking bench of the counter channel
`timescale 1ns/1ps
module test_gated_quadrature_pulse_counter;
    import gqpc_pkg::*;
    logic i_clk, i_rst, i_ce, i_wr, i_rd, i_gate_input, a, b, o_irq;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata, d;
    int fail_count = 0;
    int samples_checked = 0;
    gated_quadrature_pulse_counter i_gated_quadrature_pulse_counter (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_count_input_a(a), .i_count_input_b(b),
        .i_gate_input(i_gate_input), .o_rdata(o_rdata), .o_irq(o_irq));
    encoder_source_model i_encoder_source_model (.i_clk(i_clk), .o_a(a), .o_b(b));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= ad;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= ad;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    function automatic logic [31:0] cfg(input logic [1:0] m, input logic rl, rp,
        input logic [1:0] gm, input logic gl, rt);
        return {23'h0, ctrl_s'{rt, gl, gm, rp, rl, m, 1'b1}};
    endfunction
    task automatic start(input logic [31:0] c, input logic [31:0] p);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CLEAR, 32'h3);
        wr(OFS_PRESET, p);
        wr(OFS_CTRL, c);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        rd(OFS_CTRL);
        chk(d, 32'h0);
        rd(8'h1c);
        chk(d, 32'h0);
        wr(OFS_PRESET, 32'hffff_ff55);
        rd(OFS_PRESET);
        chk(d, 32'h0fff_ff55);
        wr(OFS_VALUE, 32'h5);
        rd(OFS_VALUE);
        chk(d, 32'h0);
        i_encoder_source_model.pulse(1'b1);
        rd(OFS_VALUE);
        chk(d, 32'h0);
    endtask
    task automatic t_quad();
        for (int i = 1; i < 4; i++) begin
            i_encoder_source_model.hold = (i == 3) ? 12 : 6;
            start(cfg(i[1:0], 1'b0, 1'b1, GATE_OFF, 1'b0, 1'b0), 32'h33);
            repeat (4) i_encoder_source_model.quad(1'b1);
            rd(OFS_VALUE);
            chk(d, 32'h33 + (32'h1 << (i - 1)));
            repeat (4) i_encoder_source_model.quad(1'b0);
            rd(OFS_VALUE);
            chk(d, 32'h33);
        end
        i_encoder_source_model.hold = 6;
    endtask
    task automatic t_pulse();
        start(cfg(MODE_PULSE_DIR, 1'b0, 1'b1, GATE_OFF, 1'b0, 1'b0), 32'h33);
        repeat (3) i_encoder_source_model.pulse(1'b1);
        i_encoder_source_model.pulse(1'b0);
        rd(OFS_VALUE);
        chk(d, 32'h35);
    endtask
    task automatic t_limit(input logic rl, rp, input logic [31:0] exp);
        wr(OFS_IRQ_EN, 32'h1);
        start(cfg(MODE_PULSE_DIR, rl, rp, GATE_OFF, 1'b0, 1'b0), 32'hffffffe);
        repeat (3) i_encoder_source_model.pulse(1'b1);
        rd(OFS_VALUE);
        chk(d, exp);
        rd(OFS_STATUS);
        chk(d, 32'h1);
        chk(o_irq, 1'b1);
        rd(OFS_RUN);
        chk(d, rp ? 32'h5 : 32'h6);
    endtask
    task automatic t_under();
        start(cfg(MODE_PULSE_DIR, 1'b0, 1'b0, GATE_OFF, 1'b0, 1'b0), 32'h1);
        repeat (3) i_encoder_source_model.pulse(1'b0);
        rd(OFS_VALUE);
        chk(d, 32'h0);
        rd(OFS_STATUS);
        chk(d, 32'h2);
        chk(o_irq, 1'b0);
    endtask
    task automatic t_gate(input logic [1:0] gm, input logic gl, rt, s, input int n);
        i_gate_input <= s;
        start(cfg(MODE_PULSE_DIR, 1'b0, 1'b1, gm, gl, rt), 32'h33);
        for (int k = 0; k < 4; k++) begin
            i_gate_input <= s ^ k[0];
            repeat (8) @(posedge i_clk);
            i_encoder_source_model.pulse(1'b1);
        end
        rd(OFS_VALUE);
        chk(d, 32'h33 + n);
    endtask
    // Clock enable low freezes the channel, then a reset in mid-run
    task automatic t_freeze();
        start(cfg(MODE_PULSE_DIR, 1'b0, 1'b1, GATE_OFF, 1'b0, 1'b0), 32'h33);
        @(posedge i_clk);
        i_ce <= 1'b0;
        i_encoder_source_model.pulse(1'b1);
        @(posedge i_clk);
        i_ce <= 1'b1;
        rd(OFS_VALUE);
        chk(d, 32'h33);
        i_encoder_source_model.pulse(1'b1);
        rd(OFS_VALUE);
        chk(d, 32'h34);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(OFS_CTRL);
        chk(d, 32'h0);
        rd(OFS_VALUE);
        chk(d, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_gate_input = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        i_ce = 1'b1;
        i_rst = 1'b1;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs();
        t_quad();
        t_pulse();
        t_limit(1'b1, 1'b1, 32'hfffffff);
        t_limit(1'b1, 1'b0, 32'hffffffe);
        t_limit(1'b0, 1'b0, 32'hfffffff);
        t_under();
        t_gate(GATE_OFF, 1'b0, 1'b0, 1'b0, 4);
        t_gate(GATE_LEVEL, 1'b0, 1'b0, 1'b0, 1);
        t_gate(GATE_LEVEL, 1'b0, 1'b1, 1'b0, 2);
        t_gate(GATE_LEVEL, 1'b1, 1'b1, 1'b1, 2);
        t_gate(GATE_EDGE, 1'b0, 1'b0, 1'b0, 3);
        t_gate(GATE_EDGE, 1'b1, 1'b0, 1'b1, 3);
        t_freeze();
        results();
    end
    initial begin
        repeat (30000) @(posedge i_clk);
        fail_count++;
        results();
    end
endmodule
